// [rtl/ccsp_top.v]
// common command parser with event status, enables, status byte and query responses
// What this block does
// - clear status clears all event registers
// - clear status clears MAV only first
// - event enable loads 0..255 parameter
// - out of range leaves register, execution error
// - event enable query returns last written
// - event status query returns then clears
// - query values sent as decimal integers
// - identity query returns five comma fields
// - operation complete sets its event bit
// - operation complete query answers ascii 1
// - reset command repeats power-up reset of parser, status registers and transmitter
// - service enable loads, bit 6 dropped
// - service enable query bit 6 zero
// - status byte query bit 6 summary
// - trigger command gives one trigger pulse
// - summary bit is enabled status OR
// - execution error bit 4, unknown bit 5
// - MAV set on response, cleared after terminator
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ccsp_regs.vh"
module ccsp_top #(
   // identity fields, values arbitrary
   parameter [31:0] MAKER = "XMKR",
   parameter [31:0] MODEL = "M001",
   parameter [23:0] MAIN_VER = "1.0",
   parameter [23:0] DISP_VER = "1.0"
) (
   // clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // command characters in
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   output wire rx_ready_o,
   // response characters out
   output reg tx_valid_o,
   output reg [7:0] tx_data_o,
   input wire tx_ready_i,
   // measurement engine
   input wire exe_err_i,
   input wire dde_i,
   output reg trig_o,
   output reg rst_cmd_o
);
   localparam [2:0] S_NAME = 3'b001;
   localparam [2:0] S_PARAM = 3'b010;
   localparam [2:0] S_SKIP = 3'b100;

   reg [2:0] state_reg;
   reg [31:0] name_reg;
   reg [2:0] ncnt_reg;
   reg qry_reg;
   reg hasp_reg;
   reg [7:0] val_reg;
   reg ovf_reg;
   reg first_reg;
   reg [7:0] esr_reg;
   reg [7:0] ese_reg;
   reg [7:0] sre_reg;
   reg mav_reg;
   reg [27:0] serial_reg;
   reg tx_busy_reg;
   reg tx_prime_reg;
   reg tx_idn_reg;
   reg [4:0] tx_idx_reg;

   reg [7:0] c;
   reg acc, sep, digit, space, exec, perr, bad;
   reg do_cls, do_ese, do_sre, do_opc, do_rst, do_trg, do_esrq, exe_p;
   reg resp_go, resp_idn;
   reg [7:0] resp_val;
   reg [11:0] v10;
   reg [7:0] esr_set;
   reg [7:0] stb;
   reg [4:0] nidx;
   reg [199:0] idn_sh;
   reg [23:0] num_sh;
   reg [7:0] nbyte;
   wire srst;
   wire [23:0] fstr;
   wire [1:0] flen;
   wire [55:0] serial_asc;
   wire [199:0] idn_str;
   wire apb_wr;
   wire hit;

   // serial number digits to ascii
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_ser
         assign serial_asc[8*g +: 8] = {4'h3, serial_reg[4*g +: 4]};
      end
   endgenerate

   assign idn_str = {MAKER, `CCSP_CH_COMMA, MODEL, `CCSP_CH_COMMA, serial_asc,
      `CCSP_CH_COMMA, MAIN_VER, `CCSP_CH_COMMA, DISP_VER};

   // input stalls while a response drains
   assign rx_ready_o = ~tx_busy_reg;
   // reset command acts as power-up reset for parser, status registers and transmitter
   assign srst = ~rst_n_i | do_rst;

   // character classification and parse errors
   always @* begin
      c = rx_data_i;
      if (rx_data_i >= 8'h61 && rx_data_i <= 8'h7A) begin
         c = rx_data_i - 8'h20;
      end
      acc = rx_valid_i & ~tx_busy_reg;
      sep = (c == `CCSP_CH_LF) | (c == `CCSP_CH_CR) | (c == `CCSP_CH_SEMI);
      digit = (c >= `CCSP_CH_0) & (c <= `CCSP_CH_9);
      space = (c == `CCSP_CH_SP);
      v10 = {4'h0, val_reg} * 12'h00A + {8'h00, c[3:0]};
      exec = acc & sep & ~state_reg[2] & (ncnt_reg != 3'h0);
      perr = acc & ~sep & ((state_reg[0] & (ncnt_reg == 3'h4) & (c != `CCSP_CH_QM) & ~space)
         | (state_reg[1] & ~digit & ~space));
   end

   // command decode
   always @* begin
      bad = 1'b0;
      do_cls = 1'b0;
      do_ese = 1'b0;
      do_sre = 1'b0;
      do_opc = 1'b0;
      do_rst = 1'b0;
      do_trg = 1'b0;
      do_esrq = 1'b0;
      exe_p = 1'b0;
      resp_go = 1'b0;
      resp_idn = 1'b0;
      resp_val = 8'h00;
      if (exec) begin
         case (name_reg)
            `CCSP_C_CLS: begin
               bad = qry_reg;
               do_cls = ~qry_reg;
            end
            `CCSP_C_ESE: begin
               resp_go = qry_reg;
               resp_val = ese_reg;
               exe_p = ~qry_reg & (~hasp_reg | ovf_reg);
               do_ese = ~qry_reg & hasp_reg & ~ovf_reg;
            end
            `CCSP_C_SRE: begin
               resp_go = qry_reg;
               resp_val = sre_reg;
               exe_p = ~qry_reg & (~hasp_reg | ovf_reg);
               do_sre = ~qry_reg & hasp_reg & ~ovf_reg;
            end
            `CCSP_C_ESR: begin
               bad = ~qry_reg;
               resp_go = qry_reg;
               do_esrq = qry_reg;
               resp_val = esr_reg;
            end
            `CCSP_C_IDN: begin
               bad = ~qry_reg;
               resp_go = qry_reg;
               resp_idn = 1'b1;
            end
            `CCSP_C_OPC: begin
               resp_go = qry_reg;
               resp_val = 8'h01;
               do_opc = ~qry_reg;
            end
            `CCSP_C_STB: begin
               bad = ~qry_reg;
               resp_go = qry_reg;
               resp_val = stb;
            end
            `CCSP_C_TST: begin
               bad = ~qry_reg;
               resp_go = qry_reg;
               resp_val = 8'h00;
            end
            `CCSP_C_RST: begin
               bad = qry_reg;
               do_rst = ~qry_reg;
            end
            `CCSP_C_TRG: begin
               bad = qry_reg;
               do_trg = ~qry_reg;
            end
            `CCSP_C_WAI: begin
               bad = qry_reg;
            end
            default: begin
               bad = 1'b1;
            end
         endcase
      end
   end

   // status byte and event inputs
   always @* begin
      esr_set = 8'h00;
      esr_set[`CCSP_ESR_OPC] = do_opc;
      esr_set[`CCSP_ESR_QYE] = apb_wr & (paddr_i == `CCSP_A_CTRL) & pwdata_i[`CCSP_CTRL_QYE];
      esr_set[`CCSP_ESR_DDE] = dde_i
         | (apb_wr & (paddr_i == `CCSP_A_CTRL) & pwdata_i[`CCSP_CTRL_DDE]);
      esr_set[`CCSP_ESR_EXE] = exe_p | exe_err_i;
      esr_set[`CCSP_ESR_CME] = bad | perr;
      stb = 8'h00;
      stb[`CCSP_STB_MAV] = mav_reg;
      stb[`CCSP_STB_ESB] = |(esr_reg & ese_reg);
      stb[`CCSP_STB_MSS] = |(stb & sre_reg & `CCSP_SRE_MASK);
   end

   // parser state
   always @(posedge mclk_i) begin
      if (srst) begin
         state_reg <= S_NAME;
         name_reg <= 32'h00000000;
         ncnt_reg <= 3'h0;
         qry_reg <= 1'b0;
         hasp_reg <= 1'b0;
         val_reg <= 8'h00;
         ovf_reg <= 1'b0;
         first_reg <= 1'b1;
      end else if (acc) begin
         if (sep) begin
            state_reg <= S_NAME;
            name_reg <= 32'h00000000;
            ncnt_reg <= 3'h0;
            qry_reg <= 1'b0;
            hasp_reg <= 1'b0;
            val_reg <= 8'h00;
            ovf_reg <= 1'b0;
            if (c != `CCSP_CH_SEMI) begin
               first_reg <= 1'b1;
            end else if (exec) begin
               first_reg <= 1'b0;
            end
         end else if (perr) begin
            state_reg <= S_SKIP;
         end else begin
            case (state_reg)
               S_NAME: begin
                  if (c == `CCSP_CH_QM) begin
                     qry_reg <= 1'b1;
                  end else if (space) begin
                     if (ncnt_reg != 3'h0) begin
                        state_reg <= S_PARAM;
                     end
                  end else if (!qry_reg) begin
                     name_reg <= {name_reg[23:0], c};
                     ncnt_reg <= ncnt_reg + 3'h1;
                  end
               end
               S_PARAM: begin
                  if (digit) begin
                     hasp_reg <= 1'b1;
                     val_reg <= v10[7:0];
                     if (v10 > `CCSP_PMAX) begin
                        ovf_reg <= 1'b1;
                     end
                  end
               end
               S_SKIP: begin
                  state_reg <= S_SKIP;
               end
               default: begin
                  state_reg <= S_NAME;
               end
            endcase
         end
      end
   end

   // status registers; a set in the clearing cycle survives
   always @(posedge mclk_i) begin
      if (srst) begin
         esr_reg <= `CCSP_ESR_RST;
         ese_reg <= `CCSP_EN_RST;
         sre_reg <= `CCSP_EN_RST;
         mav_reg <= 1'b0;
      end else begin
         // clear status and event query clear
         if (do_cls | do_esrq) begin
            esr_reg <= esr_set;
         end else begin
            esr_reg <= esr_reg | esr_set;
         end
         if (do_ese) begin
            ese_reg <= val_reg;
         end
         if (do_sre) begin
            sre_reg <= val_reg & `CCSP_SRE_MASK;
         end
         if (resp_go) begin
            mav_reg <= 1'b1;
         end else if (tx_valid_o & tx_ready_i & (tx_data_o == `CCSP_CH_LF)) begin
            mav_reg <= 1'b0;
         end else if (do_cls & first_reg) begin
            mav_reg <= 1'b0;
         end
      end
   end

   ccsp_fmt u_fmt (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .load_i(resp_go),
      .val_i(resp_val),
      .str_o(fstr),
      .len_o(flen)
   );

   // next response character
   always @* begin
      nidx = tx_prime_reg ? 5'h00 : tx_idx_reg + 5'h01;
      idn_sh = idn_str << {nidx, 3'b000};
      num_sh = fstr << {nidx, 3'b000};
      if (tx_idn_reg) begin
         nbyte = (nidx < `CCSP_IDN_LEN) ? idn_sh[199:192] : `CCSP_CH_LF;
      end else begin
         nbyte = (nidx < {3'h0, flen}) ? num_sh[23:16] : `CCSP_CH_LF;
      end
   end

   // response transmitter, one character held until taken
   always @(posedge mclk_i) begin
      if (srst) begin
         tx_busy_reg <= 1'b0;
         tx_prime_reg <= 1'b0;
         tx_idn_reg <= 1'b0;
         tx_idx_reg <= 5'h00;
         tx_valid_o <= 1'b0;
         tx_data_o <= 8'h00;
      end else if (resp_go) begin
         tx_busy_reg <= 1'b1;
         tx_prime_reg <= 1'b1;
         tx_idn_reg <= resp_idn;
      end else if (tx_prime_reg) begin
         tx_prime_reg <= 1'b0;
         tx_valid_o <= 1'b1;
         tx_data_o <= nbyte;
         tx_idx_reg <= 5'h00;
      end else if (tx_valid_o & tx_ready_i) begin
         if (tx_data_o == `CCSP_CH_LF) begin
            tx_valid_o <= 1'b0;
            tx_busy_reg <= 1'b0;
         end else begin
            tx_data_o <= nbyte;
            tx_idx_reg <= nidx;
         end
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         trig_o <= 1'b0;
         rst_cmd_o <= 1'b0;
      end else begin
         trig_o <= do_trg;
         rst_cmd_o <= do_rst;
      end
   end

   // apb slave, zero wait, read data latched in setup
   assign pready_o = 1'b1;
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign hit = (paddr_i == `CCSP_A_CTRL) | (paddr_i == `CCSP_A_STAT)
      | (paddr_i == `CCSP_A_SERIAL);
   assign pslverr_o = psel_i & penable_i & ~hit;

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h00000000;
         serial_reg <= `CCSP_SERIAL_RST;
      end else begin
         if (psel_i & ~penable_i) begin
            case (paddr_i)
               `CCSP_A_STAT: prdata_o <= {sre_reg, ese_reg, esr_reg, stb};
               `CCSP_A_SERIAL: prdata_o <= {4'h0, serial_reg};
               default: prdata_o <= 32'h00000000;
            endcase
         end
         // serial digits steer the identity answer
         if (apb_wr & (paddr_i == `CCSP_A_SERIAL)) begin
            serial_reg <= pwdata_i[27:0];
         end
      end
   end
endmodule

// [include/ccsp_regs.vh]
// register offsets, field positions, reset values and codes of the command status parser
`ifndef CCSP_REGS_VH
`define CCSP_REGS_VH

// apb register byte offsets
`define CCSP_A_CTRL 8'h00
`define CCSP_A_STAT 8'h04
`define CCSP_A_SERIAL 8'h08

// control register bits, write one to pulse
`define CCSP_CTRL_DDE 0
`define CCSP_CTRL_QYE 1

// event status register bits
`define CCSP_ESR_OPC 0
`define CCSP_ESR_QYE 2
`define CCSP_ESR_DDE 3
`define CCSP_ESR_EXE 4
`define CCSP_ESR_CME 5
`define CCSP_ESR_PON 7

// status byte bits
`define CCSP_STB_MAV 4
`define CCSP_STB_ESB 5
`define CCSP_STB_MSS 6

// reset values and masks
`define CCSP_ESR_RST 8'h80
`define CCSP_EN_RST 8'h00
`define CCSP_SERIAL_RST 28'h0000000
`define CCSP_SRE_MASK 8'hBF
`define CCSP_PMAX 12'h0FF
`define CCSP_IDN_LEN 5'h19

// ascii characters
`define CCSP_CH_LF 8'h0A
`define CCSP_CH_CR 8'h0D
`define CCSP_CH_SP 8'h20
`define CCSP_CH_COMMA 8'h2C
`define CCSP_CH_0 8'h30
`define CCSP_CH_9 8'h39
`define CCSP_CH_SEMI 8'h3B
`define CCSP_CH_QM 8'h3F

// command names, four ascii characters each
`define CCSP_C_CLS 32'h2A434C53
`define CCSP_C_ESE 32'h2A455345
`define CCSP_C_ESR 32'h2A455352
`define CCSP_C_IDN 32'h2A49444E
`define CCSP_C_OPC 32'h2A4F5043
`define CCSP_C_RST 32'h2A525354
`define CCSP_C_SRE 32'h2A535245
`define CCSP_C_STB 32'h2A535442
`define CCSP_C_TRG 32'h2A545247
`define CCSP_C_TST 32'h2A545354
`define CCSP_C_WAI 32'h2A574149

`endif

// [rtl/ccsp_fmt.v]
// binary byte to left-aligned decimal ascii digits
`timescale 1ns/10ps
`include "ccsp_regs.vh"
module ccsp_fmt (
   // clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // value in
   input wire load_i,
   input wire [7:0] val_i,
   // digits out, most significant first
   output reg [23:0] str_o,
   output reg [1:0] len_o
);
   reg [7:0] hun;
   reg [7:0] ten;
   reg [7:0] one;

   always @* begin
      hun = val_i / 8'h64;
      ten = (val_i / 8'h0A) % 8'h0A;
      one = val_i % 8'h0A;
   end

   // leading zeros dropped, zero itself is one digit
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         str_o <= 24'h000000;
         len_o <= 2'h0;
      end else if (load_i) begin
         if (hun != 8'h00) begin
            str_o <= {hun + `CCSP_CH_0, ten + `CCSP_CH_0, one + `CCSP_CH_0};
            len_o <= 2'h3;
         end else if (ten != 8'h00) begin
            str_o <= {ten + `CCSP_CH_0, one + `CCSP_CH_0, 8'h00};
            len_o <= 2'h2;
         end else begin
            str_o <= {one + `CCSP_CH_0, 16'h0000};
            len_o <= 2'h1;
         end
      end
   end
endmodule

// [dv/ccsp_chk_assertions.sv]
// port assertions of the command status parser
`timescale 1ns/10ps
module ccsp_chk (
   // clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // apb
   input wire psel_i,
   input wire penable_i,
   input wire [7:0] paddr_i,
   input wire pslverr_o,
   // characters
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   input wire rx_ready_o,
   input wire tx_valid_o,
   input wire [7:0] tx_data_o,
   input wire tx_ready_i,
   // engine
   input wire trig_o,
   input wire rst_cmd_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire took = rx_valid_i && rx_ready_o;
   wire term = took && (rx_data_i == 8'h0A || rx_data_i == 8'h0D || rx_data_i == 8'h3B);
   // query mark right before the terminator
   sequence s_query;
      took && rx_data_i == 8'h3F ##1 term;
   endsequence
   sequence s_lf_out;
      tx_valid_o && tx_ready_i && tx_data_o == 8'h0A;
   endsequence
   a_query_answer: assert property (s_query |=> !rx_ready_o ##1 tx_valid_o)
      else $error("query answer not started in time");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("answer char not held");
   a_rx_block: assert property (tx_valid_o |-> !rx_ready_o)
      else $error("input taken while answering");
   a_lf_end: assert property (s_lf_out |=> !tx_valid_o && rx_ready_o)
      else $error("answer not closed after terminator");
   a_trig_cause: assert property (trig_o |-> $past(term))
      else $error("trigger without terminator");
   a_trig_pulse: assert property (trig_o |=> !trig_o)
      else $error("trigger wider than one cycle");
   a_rst_cause: assert property (rst_cmd_o |-> $past(term) && !trig_o)
      else $error("reset pulse without terminator");
   // sync reset must leave answer and pulse outputs idle and input ready at release
   a_rst_idle: assert property ($rose(rst_n_i) |->
      !tx_valid_o && !trig_o && !rst_cmd_o && rx_ready_o)
      else $error("outputs not idle after reset");
   a_apb_err: assert property (psel_i && penable_i |->
      pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08}))
      else $error("error response wrong for address");
endmodule

// [dv/ccsp_host.sv]
// host model: sends command lines, sinks answers with random stalls
`timescale 1ns/10ps
module ccsp_host (
   // clock
   input wire mclk_i,
   // command characters
   input wire rdy_i,
   output logic vld_o,
   output logic [7:0] chr_o,
   // answer sink
   output logic snk_rdy_o
);
   initial begin
      vld_o = 1'b0;
      chr_o = 8'hA5;
      snk_rdy_o = 1'b0;
   end
   // slow reader at times, so held answer chars get exercised
   always @(posedge mclk_i) snk_rdy_o <= ($urandom % 3) != 0;
   // ascii text, one char per handshake
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         vld_o <= 1'b1;
         chr_o <= s[i];
         @(posedge mclk_i);
         while (rdy_i !== 1'b1) @(posedge mclk_i);
      end
      // released line must not keep showing the last char
      vld_o <= 1'b0;
      chr_o <= ~chr_o;
      @(posedge mclk_i);
   endtask
endmodule

// [dv/tb_ccsp_top.sv]
// bench of the command status parser with a host model
`timescale 1ns/10ps
module tb_ccsp_top;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic exe_err_i = 1'b0;
   logic dde_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h00000000;
   wire [31:0] prdata_o;
   wire [7:0] rx_data_i, tx_data_o;
   wire pready_o, pslverr_o, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, trig_o, rst_cmd_o;
   int failures = 0, num_checks = 0, cycles = 0, trigs = 0, rsts = 0;
   string expq[$], line = "";
   logic [32:0] apbq[$];
   initial forever #10 mclk_i = ~mclk_i;
   ccsp_top dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i),
      .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .exe_err_i(exe_err_i), .dde_i(dde_i),
      .trig_o(trig_o), .rst_cmd_o(rst_cmd_o)
   );
   ccsp_host host (
      .mclk_i(mclk_i), .rdy_i(rx_ready_o), .vld_o(rx_valid_i), .chr_o(rx_data_i),
      .snk_rdy_o(tx_ready_i)
   );
   task end_sim();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // idle cycle after release, so back to back calls never collide
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      @(posedge mclk_i);
      while (pready_o !== 1'b1) @(posedge mclk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apbq.push_back(e);
      apb(1'b0, a, 32'h00000000);
   endtask
   // answers read before the next line
   task automatic cmd(input string s, input string a = "");
      if (a != "") expq.push_back(a);
      host.send({s, "\n"});
      while (expq.size() != 0) @(posedge mclk_i);
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (trig_o === 1'b1) trigs++;
      if (rst_cmd_o === 1'b1) rsts++;
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
         num_checks++;
         if (apbq.size() == 0 || {pslverr_o, prdata_o} !== apbq[0]) begin
            failures++;
            $display("CHECK FAILED at %0t: read %h", $time, prdata_o);
         end
         if (apbq.size() != 0) void'(apbq.pop_front());
      end
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
         if (tx_data_o !== 8'h0A) line = $sformatf("%s%c", line, tx_data_o);
         else begin
            num_checks++;
            if (expq.size() == 0 || line != expq[0]) begin
               failures++;
               $display("CHECK FAILED at %0t: answer %s", $time, line);
            end
            if (expq.size() != 0) void'(expq.pop_front());
            line = "";
         end
      end
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      int v;
      void'($urandom(37));
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(8'h04, 33'h000008000);
      cmd("*ESR?", "128");
      rd(8'h04, 33'h000000000);
      cmd("*ESE 16");
      cmd("*ESE 256");
      cmd("*ese?", "16");
      cmd("*ESR?", "16");
      cmd("*SRE 255");
      cmd("*SRE 300");
      cmd("*SRE?", "191");
      cmd("*STB?", "96");
      cmd("*ESR?", "16");
      cmd("*XYZ");
      cmd("*ESR?", "32");
      cmd("*ESE");
      cmd("*SRE 1X");
      cmd("*TRGX");
      cmd("*ESR?", "48");
      cmd("*OPC");
      rd(8'h04, 33'h0BF100100);
      cmd("*CLS");
      rd(8'h04, 33'h0BF100000);
      exe_err_i <= 1'b1;
      dde_i <= 1'b1;
      @(posedge mclk_i);
      exe_err_i <= 1'b0;
      dde_i <= 1'b0;
      apb(1'b1, 8'h00, 32'h00000003);
      cmd("*ESR?", "28");
      rd(8'h0C, 33'h100000000);
      cmd("*WAI");
      cmd("*ESR?", "0");
      expq.push_back("1");
      cmd("*OPC?;*TST?", "0");
      apb(1'b1, 8'h08, 32'h01234567);
      rd(8'h08, 33'h001234567);
      cmd("*IDN?", "XMKR,M001,1234567,1.0,1.0");
      // status read while an answer drains: MAV and summary up
      fork
         cmd("*IDN?", "XMKR,M001,1234567,1.0,1.0");
         begin
            @(posedge mclk_i);
            while (tx_valid_o !== 1'b1) @(posedge mclk_i);
            rd(8'h04, 33'h0BF100050);
         end
      join
      for (int i = 0; i < 5; i++) begin
         v = (i == 0) ? 0 : (i == 1) ? 255 : $urandom % 256;
         cmd($sformatf("*ESE %0d", v));
         cmd("*ESE?", $sformatf("%0d", v));
      end
      cmd("*TRG");
      cmd("*RST");
      rd(8'h04, 33'h000008000);
      num_checks++;
      if (trigs != 1 || rsts != 1) begin
         failures++;
         $display("CHECK FAILED at %0t: pulse count", $time);
      end
      end_sim();
   end
endmodule
bind ccsp_top ccsp_chk chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i),
   .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
   .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .trig_o(trig_o), .rst_cmd_o(rst_cmd_o)
);
